/* File: i2tl_div_if.sv */
/*
  Handshake carrier between the limiter and its shared divider.
  Assumes both ends run on the same clock; start is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none

interface i2tl_div_if #(
  parameter int DW = 96,
  parameter int VW = 64
);
  logic          start;
  logic [DW-1:0] dividend;
  logic [VW-1:0] divisor;
  logic          busy;
  logic          done;
  logic [31:0]   quotient;

  modport master (output start, output dividend, output divisor,
                  input busy, input done, input quotient);
  modport slave  (input start, input dividend, input divisor,
                  output busy, output done, output quotient);
endinterface

`default_nettype wire

/* File: i2tl_divider.sv */
/*
  Iterative restoring divider, one quotient bit per clock.
  Assumes start only while busy is low; quotient saturates at 32 bits
  and a zero divisor gives all ones.
*/
`timescale 1ns/1ps
`default_nettype none

module i2tl_divider #(
  parameter int DW = 96,
  parameter int VW = 64
) (
  input  wire logic  clock,
  input  wire logic  rst_n,
  i2tl_div_if.slave  dv
);
  logic [VW:0]   rem_ff;
  logic [DW-1:0] quo_ff;
  logic [VW-1:0] den_ff;
  logic [7:0]    cnt_ff;
  logic          busy_ff;
  logic          done_ff;
  logic [31:0]   res_ff;
  logic [VW:0]   rem_sh;

  assign rem_sh      = {rem_ff[VW-1:0], quo_ff[DW-1]};
  assign dv.busy     = busy_ff;
  assign dv.done     = done_ff;
  assign dv.quotient = res_ff;

  // ==========================================================================
  // shift and subtract
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rem_ff  <= '0;
      quo_ff  <= '0;
      den_ff  <= '0;
      cnt_ff  <= 8'h00;
      busy_ff <= 1'b0;
    end else if (dv.start && !busy_ff) begin
      rem_ff  <= '0;
      quo_ff  <= dv.dividend;
      den_ff  <= dv.divisor;
      cnt_ff  <= 8'(DW);
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      if (cnt_ff != 8'h00) begin
        if (rem_sh >= {1'b0, den_ff}) begin
          rem_ff <= rem_sh - {1'b0, den_ff};
          quo_ff <= {quo_ff[DW-2:0], 1'b1};
        end else begin
          rem_ff <= rem_sh;
          quo_ff <= {quo_ff[DW-2:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 8'h01;
      end
      // busy stays up for one idle step so the result register sees the last quotient bit
      busy_ff <= (cnt_ff != 8'h00);
    end
  end

  // ==========================================================================
  // result register, saturated to the reported width
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      res_ff  <= 32'h0000_0000;
    end else begin
      done_ff <= busy_ff && (cnt_ff == 8'h00);
      if (busy_ff && cnt_ff == 8'h00) begin
        if (den_ff == '0 || quo_ff[DW-1:32] != '0) begin
          res_ff <= 32'hffff_ffff;
        end else begin
          res_ff <= quo_ff[31:0];
        end
      end
    end
  end

  // busy drops one cycle after the last step, so done follows start by DW+2
  property p_div_latency;
    @(posedge clock) disable iff (!rst_n)
      (dv.start && !busy_ff) |-> ##(DW+2) done_ff;
  endproperty
  a_div_latency: assert property (p_div_latency) else $error("divider latency wrong");

endmodule

`default_nettype wire

/* File: i2tl_pkg.sv */
/*
  Constants, object-dictionary addresses and types for the motor overload
  current limiter.
  Assumes a single 125 MHz controller clock and that all settings are
  reached through the object-dictionary access port of the top module.
*/
package i2tl_pkg;

  // ==========================================================================
  // object-dictionary addresses
  localparam logic [15:0] OD_IDX_PEAK      = 16'h2031;
  localparam logic [15:0] OD_IDX_OVERLOAD  = 16'h203b;
  localparam logic [7:0]  OD_SUB_PEAK      = 8'h00;
  localparam logic [7:0]  OD_SUB_RATED     = 8'h01;
  localparam logic [7:0]  OD_SUB_DURATION  = 8'h02;
  localparam logic [7:0]  OD_SUB_THRESHOLD = 8'h03;
  localparam logic [7:0]  OD_SUB_RUNNING   = 8'h04;
  localparam logic [7:0]  OD_SUB_CEILING   = 8'h05;
  localparam logic [7:0]  OD_SUB_STATUS    = 8'h06;

  // ==========================================================================
  // reset values and codes
  localparam logic [31:0] RST_PEAK_MA      = 32'h0000_0000;
  localparam logic [31:0] RST_RATED_MA     = 32'h0000_0000;
  localparam logic [31:0] RST_DURATION_MS  = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFF       = 32'h0000_0000;
  localparam logic [31:0] STATUS_ON        = 32'h0000_0001;

  // ==========================================================================
  // timing: accumulation advances once per millisecond
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int TICK_PERIOD_NS  = 1000000;
  localparam int TICK_CYCLES     = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int MS_PER_S        = 1000;

  // ==========================================================================
  // arithmetic widths
  localparam int ACC_W  = 96;
  localparam int NORM_W = 64;

  typedef enum logic [1:0] {
    DV_IDLE,
    DV_THRESH,
    DV_VALUE
  } i2tl_dv_state_t;

endpackage

/* File: i2tl_reg_model.sv */
/*
  Behavioural model of the motor current regulator and power stage.
  Assumes the regulator follows the demanded current clipped to the ceiling
  handed over by the limiter; SLOW adds one clock of lag, so the output may
  exceed a falling ceiling for that one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module i2tl_reg_model #(
  parameter bit SLOW = 1'b0
) (
  input  wire logic        clock,
  input  wire logic [31:0] demand_ma,
  input  wire logic [31:0] current_ceiling_ma,
  output logic      [31:0] current_meas_ma
);
  // ==========================================================================
  // current follows demand, clipped by the ceiling
  logic [31:0] clipped;
  logic [31:0] lag_ff;

  assign clipped = (demand_ma > current_ceiling_ma) ? current_ceiling_ma : demand_ma;

  // the lagged path shows how a slower power stage overshoots for one cycle
  always_ff @(posedge clock) begin
    lag_ff <= clipped;
  end

  assign current_meas_ma = SLOW ? lag_ff : clipped;
endmodule

`default_nettype wire

/* File: i2tl_tb.sv */
/*
  Self-checking testbench of the motor overload current limiter.
  Assumes the object port of the top module and the regulator model above;
  the millisecond tick is shortened to 300 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ==========================================================================
  // settings of the run
  localparam int          T     = 32'h12c;
  localparam logic [31:0] PEAK  = 32'h7d0;
  localparam logic [31:0] RATED = 32'h3e8;
  localparam logic [31:0] DUR   = 32'ha;
  localparam logic [15:0] IX    = i2tl_pkg::OD_IDX_OVERLOAD;

  logic        clock = 1'b0;
  logic        nrst  = 1'b0;
  logic        od_req = 1'b0;
  logic        od_we = 1'b0;
  logic [15:0] od_index = 16'h0000;
  logic [7:0]  od_subindex = 8'h00;
  logic [31:0] od_wdata = 32'h0;
  logic [31:0] od_rdata;
  logic        od_ack;
  logic        od_err;
  logic        submode_closed_loop = 1'b1;
  logic [31:0] demand_ma = 32'h0;
  logic [31:0] current_meas_ma;
  logic [31:0] current_ceiling_ma;
  logic        overload_active;
  logic        ceiling_reduced;
  int          fails = 0;
  int          comparisons = 0;
  int          first_cyc;
  int          second_cyc;

  always #4 clock = ~clock;

  i2tl_top #(.TICK_CYCLES(T)) u_dut (
    .clock              (clock),
    .nrst               (nrst),
    .od_req             (od_req),
    .od_we              (od_we),
    .od_index           (od_index),
    .od_subindex        (od_subindex),
    .od_wdata           (od_wdata),
    .od_rdata           (od_rdata),
    .od_ack             (od_ack),
    .od_err             (od_err),
    .submode_closed_loop(submode_closed_loop),
    .current_meas_ma    (current_meas_ma),
    .current_ceiling_ma (current_ceiling_ma),
    .overload_active    (overload_active),
    .ceiling_reduced    (ceiling_reduced)
  );

  i2tl_reg_model #(.SLOW(1'b0)) u_reg (
    .clock             (clock),
    .demand_ma         (demand_ma),
    .current_ceiling_ma(current_ceiling_ma),
    .current_meas_ma   (current_meas_ma)
  );

  // ==========================================================================
  // reporting
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_test(input string what);
    $display("test %s done", what);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // ==========================================================================
  // object port access: one-cycle request, answer within a bounded wait
  task automatic od_op(input logic we, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] wd, input logic exp_err, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    od_req = 1'b1;
    od_we = we;
    od_index = idx;
    od_subindex = sub;
    od_wdata = wd;
    @(posedge clock);
    #1;
    od_req = 1'b0;
    while (od_ack !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (od_ack !== 1'b1) begin
      fails++;
      $display("CHECK FAILED od_ack expected 1 seen none");
      stop_test();
    end
    rd = od_rdata;
    check("od_err", {31'h0, od_err}, {31'h0, exp_err});
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] v,
                    input logic exp_err);
    logic [31:0] rd;
    od_op(1'b1, idx, sub, v, exp_err, rd);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] exp);
    logic [31:0] rd;
    od_op(1'b0, idx, sub, 32'h0, 1'b0, rd);
    check(what, rd, exp);
  endtask

  // counts cycles until the ceiling drops to rated current
  task automatic wait_reduced(input int max, output int cyc);
    cyc = 0;
    while (ceiling_reduced !== 1'b1 && cyc < max) begin
      @(posedge clock);
      #1;
      cyc++;
    end
    if (cyc >= max) begin
      fails++;
      $display("CHECK FAILED ceiling_reduced expected 1 seen 0");
      stop_test();
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] rd;
    cycles(2);
    nrst = 1'b1;
    cycles(6);
    check("reset_ceiling", current_ceiling_ma, 32'h0);
    check("reset_active", {31'h0, overload_active}, 32'h0);
    rd_chk("reset_peak", i2tl_pkg::OD_IDX_PEAK, i2tl_pkg::OD_SUB_PEAK, 32'h0);
    for (int s = 1; s <= 6; s++) begin
      rd_chk("reset_sub", i2tl_pkg::OD_IDX_OVERLOAD, 8'(s), 32'h0);
    end
    od_op(1'b0, i2tl_pkg::OD_IDX_OVERLOAD, 8'h07, 32'h0, 1'b1, rd);
    check("unmapped_read", rd, 32'h0);
    wr(i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_THRESHOLD, 32'h5, 1'b1);
    wr(i2tl_pkg::OD_IDX_PEAK, 8'h01, 32'h5, 1'b1);
    end_test("reset_and_map");

    wr(i2tl_pkg::OD_IDX_PEAK, i2tl_pkg::OD_SUB_PEAK, PEAK, 1'b0);
    wr(i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_RATED, RATED, 1'b0);
    cycles(2);
    check("active_no_duration", {31'h0, overload_active}, 32'h0);
    wr(i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_DURATION, DUR, 1'b0);
    cycles(2);
    check("active", {31'h0, overload_active}, 32'h1);
    check("ceiling_peak", current_ceiling_ma, PEAK);
    submode_closed_loop = 1'b0;
    cycles(2);
    check("open_loop_ceiling", current_ceiling_ma, RATED);
    submode_closed_loop = 1'b1;
    cycles(2 * T);
    check("closed_loop_ceiling", current_ceiling_ma, PEAK);
    check("not_reduced", {31'h0, ceiling_reduced}, 32'h0);
    // (peak^2-rated^2)*dur / ((peak+rated)*1000) = 10 mAs
    rd_chk("threshold", IX, i2tl_pkg::OD_SUB_THRESHOLD, 32'ha);
    rd_chk("status_on", i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_STATUS, 32'h1);
    end_test("activation");

    // each tick at peak adds 3e6 against a limit of 3e7: ten ticks to trip
    demand_ma = PEAK;
    wait_reduced(11 * T, first_cyc);
    check("first_trip_time", 32'(first_cyc inside {[9 * T : 10 * T + 4]}), 32'h1);
    cycles(2);
    check("ceiling_rated", current_ceiling_ma, RATED);
    cycles(2 * T);
    rd_chk("running_at_limit", i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_RUNNING, 32'ha);
    rd_chk("ceiling_reg", i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_CEILING, RATED);
    end_test("first_burst");

    // five ticks at zero current take away 5e6, then hold at rated
    demand_ma = 32'h0;
    cycles(5 * T);
    demand_ma = RATED;
    cycles(2 * T);
    rd_chk("running_decayed", IX, i2tl_pkg::OD_SUB_RUNNING, 32'h8);
    check("ceiling_back_peak", current_ceiling_ma, PEAK);
    demand_ma = PEAK;
    wait_reduced(3 * T, second_cyc);
    check("second_trip_time", 32'(second_cyc > T && second_cyc <= 2 * T + 4), 32'h1);
    end_test("second_burst");

    wr(i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_DURATION, 32'h0, 1'b0);
    cycles(2);
    check("inactive", {31'h0, overload_active}, 32'h0);
    check("inactive_ceiling", current_ceiling_ma, PEAK);
    cycles(2 * T);
    rd_chk("status_off", i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_STATUS, 32'h0);
    rd_chk("threshold_off", i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_THRESHOLD, 32'h0);
    wr(i2tl_pkg::OD_IDX_OVERLOAD, i2tl_pkg::OD_SUB_DURATION, DUR, 1'b0);
    wr(i2tl_pkg::OD_IDX_PEAK, i2tl_pkg::OD_SUB_PEAK, RATED, 1'b0);
    cycles(2);
    check("peak_equals_rated", {31'h0, overload_active}, 32'h0);
    end_test("deactivation");
    stop_test();
  end
endmodule

`default_nettype wire

/* File: i2tl_top.sv */
/*
  Motor overload current limiter: integrates the square of the measured
  motor current against a limit derived from rated current, peak current
  and peak duration, and hands the current ceiling to the regulator.
  Assumes the object-dictionary port and the regulator are on the same
  clock; nrst may arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - full limiting only while the closed-loop submode bit is one
// - open loop with limiting active clamps the ceiling to rated current
// - peak and rated currents are milliamperes, peak duration is milliseconds
// - active only when peak exceeds rated and duration is nonzero
// - limit derived from rated current, peak current and peak duration
// - peak allowed until limit reached, then ceiling drops to rated at once
// - threshold reported in milliampere-seconds selects peak or rated ceiling
// - running calculated value is reported and compared with the threshold
// - the ceiling applied right now is reported
// - status reads 0 while deactivated and 1 while activated
// - accumulated value is kept between episodes, so later bursts trip sooner
module i2tl_top #(
  parameter int TICK_CYCLES = i2tl_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        od_req,
  input  wire logic        od_we,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_subindex,
  input  wire logic [31:0] od_wdata,
  output logic      [31:0] od_rdata,
  output logic             od_ack,
  output logic             od_err,
  input  wire logic        submode_closed_loop,
  input  wire logic [31:0] current_meas_ma,
  output logic      [31:0] current_ceiling_ma,
  output logic             overload_active,
  output logic             ceiling_reduced
);
  localparam int AW = i2tl_pkg::ACC_W;
  localparam int NW = i2tl_pkg::NORM_W;

  logic [1:0]              rst_sync_ff;
  logic                    rst_n;
  logic [31:0]             tick_cnt_ff;
  logic                    ms_tick;
  logic [31:0]             peak_ff;
  logic [31:0]             rated_ff;
  logic [31:0]             dur_ff;
  logic [31:0]             thresh_ff;
  logic [31:0]             running_ff;
  logic [31:0]             ceiling_ff;
  logic [AW-1:0]           acc_ff;
  logic [31:0]             od_rdata_ff;
  logic                    od_ack_ff;
  logic                    od_err_ff;
  i2tl_pkg::i2tl_dv_state_t dv_state_ff;
  logic                    active;
  logic [AW-1:0]           peak_sq;
  logic [AW-1:0]           rated_sq;
  logic [AW-1:0]           meas_sq;
  logic [AW-1:0]           limit_sq;
  logic [AW-1:0]           excess;
  logic [AW-1:0]           deficit;
  logic                    limit_hit;
  logic                    hit_od;
  logic [31:0]             nxt_ceiling;
  logic [31:0]             rd_mux;
  logic                    rd_ok;

  i2tl_div_if #(.DW(AW), .VW(NW)) div_bus ();

  i2tl_divider #(.DW(AW), .VW(NW)) u_div (
    .clock (clock),
    .rst_n (rst_n),
    .dv    (div_bus)
  );

  // ==========================================================================
  // reset release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ==========================================================================
  // millisecond enable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else if (ms_tick) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
    end
  end
  assign ms_tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

  // ==========================================================================
  // limit arithmetic, all in mA^2 * ms
  assign active   = (peak_ff > rated_ff) && (dur_ff != 32'h0000_0000);
  assign peak_sq  = AW'(peak_ff) * AW'(peak_ff);
  assign rated_sq = AW'(rated_ff) * AW'(rated_ff);
  assign meas_sq  = AW'(current_meas_ma) * AW'(current_meas_ma);
  assign limit_sq = (peak_sq - rated_sq) * AW'(dur_ff);
  assign excess   = meas_sq - rated_sq;
  assign deficit  = rated_sq - meas_sq;
  assign limit_hit = (acc_ff >= limit_sq);

  // accumulator is never cleared by deactivation so history carries over
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= '0;
    end else if (ms_tick && active) begin
      if (current_meas_ma > rated_ff) begin
        acc_ff <= (acc_ff + excess < acc_ff) ? '1 : acc_ff + excess;
      end else begin
        acc_ff <= (acc_ff > deficit) ? acc_ff - deficit : '0;
      end
    end
  end

  // ==========================================================================
  // ceiling selection
  always_comb begin
    if (!active) begin
      nxt_ceiling = peak_ff;
    end else if (!submode_closed_loop) begin
      nxt_ceiling = rated_ff;
    end else if (limit_hit) begin
      nxt_ceiling = rated_ff;
    end else begin
      nxt_ceiling = peak_ff;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ceiling_ff <= i2tl_pkg::RST_PEAK_MA;
    end else begin
      ceiling_ff <= nxt_ceiling;
    end
  end
  assign current_ceiling_ma = ceiling_ff;
  assign overload_active    = active;
  assign ceiling_reduced    = active && (ceiling_ff == rated_ff);

  // ==========================================================================
  // reported values in mAs: divide by (peak + rated) * 1000
  assign div_bus.divisor = (NW'(peak_ff) + NW'(rated_ff)) * NW'(i2tl_pkg::MS_PER_S);
  assign div_bus.dividend = (dv_state_ff == i2tl_pkg::DV_IDLE) ? limit_sq : acc_ff;
  assign div_bus.start = (dv_state_ff == i2tl_pkg::DV_IDLE) ? ms_tick
                       : (dv_state_ff == i2tl_pkg::DV_THRESH) && div_bus.done;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dv_state_ff <= i2tl_pkg::DV_IDLE;
      thresh_ff   <= 32'h0000_0000;
      running_ff  <= 32'h0000_0000;
    end else begin
      case (dv_state_ff)
        i2tl_pkg::DV_IDLE: begin
          if (ms_tick) begin
            dv_state_ff <= i2tl_pkg::DV_THRESH;
          end
        end
        i2tl_pkg::DV_THRESH: begin
          if (div_bus.done) begin
            thresh_ff   <= active ? div_bus.quotient : 32'h0000_0000;
            dv_state_ff <= i2tl_pkg::DV_VALUE;
          end
        end
        i2tl_pkg::DV_VALUE: begin
          if (div_bus.done) begin
            running_ff  <= div_bus.quotient;
            dv_state_ff <= i2tl_pkg::DV_IDLE;
          end
        end
        default: begin
          dv_state_ff <= i2tl_pkg::DV_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // object-dictionary access
  assign hit_od = od_req && od_we && (od_index == i2tl_pkg::OD_IDX_PEAK
                  || od_index == i2tl_pkg::OD_IDX_OVERLOAD);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      peak_ff  <= i2tl_pkg::RST_PEAK_MA;
      rated_ff <= i2tl_pkg::RST_RATED_MA;
      dur_ff   <= i2tl_pkg::RST_DURATION_MS;
    end else if (hit_od) begin
      if (od_index == i2tl_pkg::OD_IDX_PEAK && od_subindex == i2tl_pkg::OD_SUB_PEAK) begin
        peak_ff <= od_wdata;
      end
      if (od_index == i2tl_pkg::OD_IDX_OVERLOAD) begin
        if (od_subindex == i2tl_pkg::OD_SUB_RATED) begin
          rated_ff <= od_wdata;
        end
        if (od_subindex == i2tl_pkg::OD_SUB_DURATION) begin
          dur_ff <= od_wdata;
        end
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (od_index == i2tl_pkg::OD_IDX_PEAK && od_subindex == i2tl_pkg::OD_SUB_PEAK) begin
      rd_mux = peak_ff;
    end else if (od_index == i2tl_pkg::OD_IDX_OVERLOAD) begin
      case (od_subindex)
        i2tl_pkg::OD_SUB_RATED:     rd_mux = rated_ff;
        i2tl_pkg::OD_SUB_DURATION:  rd_mux = dur_ff;
        i2tl_pkg::OD_SUB_THRESHOLD: rd_mux = thresh_ff;
        i2tl_pkg::OD_SUB_RUNNING:   rd_mux = running_ff;
        i2tl_pkg::OD_SUB_CEILING:   rd_mux = ceiling_ff;
        i2tl_pkg::OD_SUB_STATUS:
          rd_mux = active ? i2tl_pkg::STATUS_ON : i2tl_pkg::STATUS_OFF;
        default:                    rd_ok = 1'b0;
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  // writes to reported entries are refused; the stored settings stay as they were
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      od_ack_ff   <= 1'b0;
      od_err_ff   <= 1'b0;
      od_rdata_ff <= 32'h0000_0000;
    end else begin
      od_ack_ff <= od_req;
      od_err_ff <= od_req && (!rd_ok || (od_we
                   && od_index == i2tl_pkg::OD_IDX_OVERLOAD
                   && od_subindex > i2tl_pkg::OD_SUB_DURATION));
      if (od_req && !od_we) begin
        od_rdata_ff <= rd_ok ? rd_mux : 32'h0000_0000;
      end
    end
  end
  assign od_rdata = od_rdata_ff;
  assign od_ack   = od_ack_ff;
  assign od_err   = od_err_ff;

  // ==========================================================================
  // checks
  localparam int DIV_MAX = AW + 4;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_thresh_done;
    (dv_state_ff == i2tl_pkg::DV_THRESH) && div_bus.done;
  endsequence
  sequence s_value_done;
    ##[1:DIV_MAX] ((dv_state_ff == i2tl_pkg::DV_VALUE) && div_bus.done);
  endsequence

  property p_report_order;
    s_thresh_done |-> s_value_done;
  endproperty
  a_report_order: assert property (p_report_order) else $error("running value not refreshed");

  property p_open_loop;
    (active && !submode_closed_loop) |=> (ceiling_ff == $past(rated_ff));
  endproperty
  a_open_loop: assert property (p_open_loop) else $error("open loop not clamped to rated");

  property p_inactive;
    !active |=> (ceiling_ff == $past(peak_ff)) && !ceiling_reduced;
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive limiter changed ceiling");

  property p_cut;
    (active && submode_closed_loop && limit_hit) |=> (ceiling_ff == $past(rated_ff));
  endproperty
  a_cut: assert property (p_cut) else $error("ceiling not cut at limit");

  property p_peak_allowed;
    (active && submode_closed_loop && !limit_hit) |=> (ceiling_ff == $past(peak_ff));
  endproperty
  a_peak_allowed: assert property (p_peak_allowed) else $error("peak withheld below limit");

  property p_status_read;
    (od_req && !od_we && od_index == i2tl_pkg::OD_IDX_OVERLOAD
     && od_subindex == i2tl_pkg::OD_SUB_STATUS)
      |=> od_ack && (od_rdata == {31'h0000_0000, $past(active)});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_hold;
    !active |=> $stable(acc_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("accumulator lost between episodes");

  property p_grow;
    (ms_tick && active && current_meas_ma > rated_ff && acc_ff != '1)
      |=> (acc_ff > $past(acc_ff));
  endproperty
  a_grow: assert property (p_grow) else $error("accumulator did not grow");

  property p_peak_write;
    (od_req && od_we && od_index == i2tl_pkg::OD_IDX_PEAK
     && od_subindex == i2tl_pkg::OD_SUB_PEAK) |=> (peak_ff == $past(od_wdata));
  endproperty
  a_peak_write: assert property (p_peak_write) else $error("peak setting not stored");

endmodule

`default_nettype wire
